/* File: bench/adc_sequencer_registers_tb.sv */
// Purpose: Self-checking bench for the converter register block
// Assumes: Ideal comparator that answers target >= trial
// Notes: Drivers queue expected results, a monitor checks them
module adc_sequencer_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } adcs_exp_t;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [3:0] C0 = adcs_pkg::OFF_CTL0;
    localparam logic [3:0] C1 = adcs_pkg::OFF_CTL1;
    localparam logic [3:0] RH = adcs_pkg::OFF_RESH;
    localparam logic [3:0] RL = adcs_pkg::OFF_RESL;
    localparam logic [1:0] OK = adcs_pkg::RESP_OKAY;
    localparam logic [1:0] DE = adcs_pkg::RESP_DECERR;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic sleepIn = 1'b0;
    logic compareIn = 1'b0;
    adcs_pkg::adcs_ana_t anaCtl;
    logic convDone;
    logic [9:0] target = 10'h0;
    logic [9:0] last = 10'h0;
    logic [7:0] rdq;
    int doneCount = 0;
    int cyc = 0;
    int doneAt = 0;
    int t0 = 0;
    logic [3:0] strb = 4'hf;
    int base;
    int numErrors = 0;
    int totalChecks = 0;
    adcs_exp_t expR[$];
    logic [1:0] expB[$];
    logic [2:0] cks[6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int divs[6] = '{8, 16, 32, 64, adcs_pkg::RC_TAD_CYC,
        adcs_pkg::RC_TAD_CYC};

    adcs_top adcs_top_i (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleepIn(sleepIn),
        .compareIn(compareIn), .anaCtl(anaCtl), .convDone(convDone)
    );

    always #5 clk_sys = ~clk_sys;
    // Ideal comparator and completion counter
    always @(posedge clk_sys) begin
        compareIn <= (target >= anaCtl.trial);
        cyc <= cyc + 1;
        if (convDone === 1'b1) begin
            doneCount <= doneCount + 1;
            doneAt <= cyc;
        end
    end
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic fail(input string s);
        numErrors++;
        $display("[ERR] %0t %s", $time, s);
    endtask
    task automatic chk_read(input logic [31:0] d, input logic [1:0] r);
        adcs_exp_t e;
        totalChecks++;
        if (expR.size() == 0) begin
            fail("read data without expectation");
            return;
        end
        e = expR.pop_front();
        if ((((d ^ e.d) & e.m) !== 32'h0) || (r !== e.r)) fail("read mismatch");
    endtask
    task automatic chk_write(input logic [1:0] r);
        logic [1:0] e;
        totalChecks++;
        e = (expB.size() > 0) ? expB.pop_front() : 2'bxx;
        if (r !== e) fail("write response mismatch");
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] e);
        totalChecks++;
        if (got !== e) fail("output value mismatch");
    endtask
    always @(posedge clk_sys) begin
        if ((s_axi_rvalid && s_axi_rready) === 1'b1) chk_read(s_axi_rdata, s_axi_rresp);
        if ((s_axi_bvalid && s_axi_bready) === 1'b1) chk_write(s_axi_bresp);
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        expB.push_back(r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d,
                      input logic [7:0] m, input logic [1:0] r);
        expR.push_back('{{24'h0, d}, {24'hffffff, m}, r});
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        rdq = s_axi_rdata[7:0];
        s_axi_rready <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic conv(input logic [2:0] ck, input int div);
        target = 10'($urandom_range(1023));
        wr(C1, {1'b0, ck, 4'h0}, OK);
        wr(C0, 8'h61, OK);
        repeat (20) @(posedge clk_sys);
        base = doneCount;
        wr(C0, 8'h63, OK);
        t0 = cyc;
        rd(C0, 8'h63, 8'hff, OK);
        rd(C0, 8'h61, 8'hfd, OK);
        while (rdq[1] === 1'b1) rd(C0, 8'h61, 8'hfd, OK);
        repeat (3) @(posedge clk_sys);
        chk_val(16'(doneCount - base), 16'h0001);
        chk_val(16'(doneAt - t0), 16'(adcs_pkg::CONV_TADS * div));
        rd(RH, {6'h0, target[9:8]}, 8'hff, OK);
        rd(RL, target[7:0], 8'hff, OK);
        last = target;
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", numErrors, totalChecks);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #600000;
        fail("watchdog expired");
        report_and_stop();
    end

    initial begin
        logic [4:0] src;
        logic ok;
        void'($urandom(81));
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(4'(4 * i), 8'h00, 8'hff, OK);
        wr(C1, 8'hff, OK);
        rd(C1, 8'h71, 8'hff, OK);
        repeat (2) @(posedge clk_sys);
        chk_val(16'(anaCtl.refSel), 16'h0001);
        wr(C1, 8'h00, OK);
        repeat (2) @(posedge clk_sys);
        chk_val(16'(anaCtl.refSel), 16'h0000);
        strb = 4'he;
        wr(C1, 8'hff, OK);
        strb = 4'hf;
        rd(C1, 8'h00, 8'hff, OK);
        wr(C0, 8'h03, OK);
        rd(C0, 8'h01, 8'hff, OK);
        chk_val(16'(anaCtl.power), 16'h0001);
        wr(C0, 8'hfd, OK);
        rd(C0, 8'h7d, 8'hff, OK);
        for (int c = 0; c < 32; c++) begin
            src = 5'(c);
            wr(C0, {1'b0, src, 2'b01}, OK);
            rd(C0, {1'b0, src, 2'b01}, 8'hff, OK);
            ok = (src <= 5'h0f && src != 5'h08 && src != 5'h09) ||
                 (src >= 5'h18 && src <= 5'h1c);
            chk_val(16'(anaCtl.srcValid), 16'(ok));
            chk_val(16'(anaCtl.src), 16'(src));
        end
        wr(C0, 8'h00, OK);
        repeat (2) @(posedge clk_sys);
        chk_val(16'(anaCtl.power), 16'h0000);
        rd(4'h2, 8'h00, 8'hff, DE);
        wr(4'h2, 8'hff, DE);
        foreach (cks[k]) conv(cks[k], divs[k]);
        wr(RH, 8'hff, OK);
        wr(RL, 8'h5a, OK);
        rd(RH, {6'h0, last[9:8]}, 8'hff, OK);
        rd(RL, last[7:0], 8'hff, OK);
        // Abort in mid-conversion keeps the old result
        wr(C1, 8'h60, OK);
        target = ~last;
        base = doneCount;
        wr(C0, 8'h63, OK);
        repeat (100) @(posedge clk_sys);
        wr(C0, 8'h61, OK);
        rd(C0, 8'h61, 8'hff, OK);
        rd(RH, {6'h0, last[9:8]}, 8'hff, OK);
        rd(RL, last[7:0], 8'hff, OK);
        repeat (150) @(posedge clk_sys);
        chk_val(16'(doneCount - base), 16'h0000);
        chk_val(16'(anaCtl.sample), 16'h0001);
        for (int k = 0; k < 2; k++) begin
            wr(C1, {1'b0, 3'(4 * k), 4'h0}, OK);
            wr(C0, 8'h63, OK);
            repeat (300) @(posedge clk_sys);
            rd(C0, 8'h63, 8'hff, OK);
            wr(C0, 8'h61, OK);
            rd(C0, 8'h61, 8'hff, OK);
        end
        sleepIn <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wr(C0, 8'h63, OK);
        rd(C0, 8'h61, 8'hff, OK);
        chk_val(16'(anaCtl.power), 16'h0000);
        sleepIn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        report_and_stop();
    end
endmodule // adc_sequencer_registers_tb

/* File: verilog/adcs_pkg.sv */
// Purpose: Constants and types for the converter register block
// Assumes: 100 MHz system clock
// Notes: Byte offsets are word aligned on AXI4-Lite
package adcs_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 10;
    localparam int RC_TAD_NS = 4000;
    localparam int RC_TAD_CYC = (RC_TAD_NS / CLK_NS < 1) ? 1 :
        RC_TAD_NS / CLK_NS;
    localparam int CONV_TADS = 11;
    localparam int ABORT_TADS = 2;
    localparam int RES_W = 10;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV8 = 16'h0008;
    localparam logic [DIV_W-1:0] DIV16 = 16'h0010;
    localparam logic [DIV_W-1:0] DIV32 = 16'h0020;
    localparam logic [DIV_W-1:0] DIV64 = 16'h0040;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTL0 = 4'h0;
    localparam logic [3:0] OFF_CTL1 = 4'h4;
    localparam logic [3:0] OFF_RESH = 4'h8;
    localparam logic [3:0] OFF_RESL = 4'hc;
    localparam int CTL0_EN = 0;
    localparam int CTL0_GO = 1;
    localparam int CTL0_SRC = 2;
    localparam int CTL1_REF = 0;
    localparam int CTL1_CLK = 4;
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [2:0] CK_DIV8 = 3'h1;
    localparam logic [2:0] CK_DIV16 = 3'h5;
    localparam logic [2:0] CK_DIV32 = 3'h2;
    localparam logic [2:0] CK_DIV64 = 3'h6;
    localparam logic [4:0] SRC_INT_LAST = 5'h0f;
    localparam logic [4:0] SRC_RSV_A = 5'h08;
    localparam logic [4:0] SRC_RSV_B = 5'h09;
    localparam logic [4:0] SRC_PIN_FIRST = 5'h18;
    localparam logic [4:0] SRC_PIN_BIG = 5'h1d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic power;
        logic refSel;
        logic sample;
        logic srcValid;
        logic [4:0] src;
        logic [RES_W-1:0] trial;
    } adcs_ana_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_RECOV = 3'b100
    } adcs_state_t;
endpackage

/* File: verilog/adcs_top.sv */
// Purpose: Register and sequencing logic of a 10-bit SAR converter
// Assumes: AXI4-Lite master, comparator and sleep come from pins
// Notes: Analog front end lies outside; anaCtl steers it
// Notes on behaviour
// R1: No conversion while device sleeps
// R2: Source field bits 6-2 selects internal nodes
// R3: Codes 01000, 01001, 10000-10111 select nothing
// R4: Codes 11000-11100 pins; 11101-11111 big package
// R5: Writing go starts; reads one while busy
// R6: Hardware clears go bit on completion
// R7: Enable bit powers converter; cleared draws nothing
// R8: Clock field bits 6-4 picks conversion clock
// R9: Clock codes 000 and 100 give no clock
// R10: Reference bit zero analog supply, one 5 V
// R11: Upper result holds bits 9-8, rest zero
// R12: Lower result holds bits 7-0, read-only
// R13: Unimplemented control bits read zero
// R14: Control bits read/write, zero after reset
// R15: Software waits acquisition before starting
// R16: Software configures, enables, waits, then starts
// R17: Software polls go or interrupt, then reads
// R18: Software clears completion flag after reading
// R19: Sampling capacitor never discharged between conversions
// R20: Result spans 1024 codes
// R21: Completion loads result, pulses flag, clears go
// R22: Clearing go aborts; restart after two periods
// R23: Conversion takes eleven conversion clock periods
// R24: Start ignored while converter disabled
// R25: Writes to result registers ignored
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
module adcs_top #(
    parameter bit LARGE_PKG = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleepIn,
    input wire logic compareIn,
    output adcs_pkg::adcs_ana_t anaCtl,
    output logic convDone
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sleepMeta, sleepSync, cmpMeta, cmpSync;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sleepMeta <= 1'b0;
            sleepSync <= 1'b0;
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
        end else begin
            sleepMeta <= sleepIn;
            sleepSync <= sleepMeta;
            cmpMeta <= compareIn;
            cmpSync <= cmpMeta;
        end
    end

    // ----------------------------------------
    // Bus write path
    // ----------------------------------------
    logic awHeld, wHeld;
    logic [adcs_pkg::ADDR_W-1:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    wire commit = awHeld && wHeld;
    wire awHit = commit && (awAddr == adcs_pkg::OFF_CTL0 ||
        awAddr == adcs_pkg::OFF_CTL1 || awAddr == adcs_pkg::OFF_RESH ||
        awAddr == adcs_pkg::OFF_RESL); // R25
    wire wrCtl0 = commit && wLane && awAddr == adcs_pkg::OFF_CTL0;
    wire wrCtl1 = commit && wLane && awAddr == adcs_pkg::OFF_CTL1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wByte <= 8'h00;
            wLane <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adcs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (commit) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= awHit ? adcs_pkg::RESP_OKAY :
                    adcs_pkg::RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic convEn, goBit, refSel;
    logic [4:0] srcSel;
    logic [2:0] clkSel;
    logic [adcs_pkg::RES_W-1:0] result;
    adcs_pkg::adcs_state_t state;
    logic [3:0] bitCnt;
    logic done;
    wire asleepOrOff = sleepSync || !convEn;
    wire startReq = wrCtl0 && wByte[adcs_pkg::CTL0_GO] && !goBit &&
        !asleepOrOff && state == adcs_pkg::ST_IDLE; // R24 R1
    wire abortSw = wrCtl0 && !wByte[adcs_pkg::CTL0_GO] && goBit; // R22
    wire abortHw = goBit && (sleepSync ||
        (wrCtl0 && !wByte[adcs_pkg::CTL0_EN])); // R1 R7
    wire abort = (abortSw || abortHw) && !done;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            convEn <= adcs_pkg::CTL0_RST[adcs_pkg::CTL0_EN]; // R14
            srcSel <= adcs_pkg::CTL0_RST[adcs_pkg::CTL0_SRC+:5];
            refSel <= adcs_pkg::CTL1_RST[adcs_pkg::CTL1_REF];
            clkSel <= adcs_pkg::CTL1_RST[adcs_pkg::CTL1_CLK+:3];
        end else begin
            if (wrCtl0) begin
                convEn <= wByte[adcs_pkg::CTL0_EN]; // R7
                srcSel <= wByte[adcs_pkg::CTL0_SRC+:5]; // R2
            end
            if (wrCtl1) begin
                refSel <= wByte[adcs_pkg::CTL1_REF]; // R10
                clkSel <= wByte[adcs_pkg::CTL1_CLK+:3]; // R8
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            goBit <= adcs_pkg::CTL0_RST[adcs_pkg::CTL0_GO];
        end else if (startReq) begin
            goBit <= 1'b1; // R5
        end else if (done || abort) begin
            goBit <= 1'b0; // R6 R22
        end
    end

    // ----------------------------------------
    // Conversion clock divider
    // ----------------------------------------
    logic [adcs_pkg::DIV_W-1:0] divCnt, divLimit;
    always_comb begin
        case (clkSel)
            adcs_pkg::CK_DIV8: divLimit = adcs_pkg::DIV8; // R8
            adcs_pkg::CK_DIV16: divLimit = adcs_pkg::DIV16;
            adcs_pkg::CK_DIV32: divLimit = adcs_pkg::DIV32;
            adcs_pkg::CK_DIV64: divLimit = adcs_pkg::DIV64;
            3'h3, 3'h7: divLimit = adcs_pkg::DIV_W'(adcs_pkg::RC_TAD_CYC);
            default: divLimit = '0; // R9
        endcase
    end
    wire noClk = divLimit == '0;
    wire tadTick = !noClk && divCnt == divLimit - 1'b1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt <= '0;
        end else if (state == adcs_pkg::ST_IDLE || tadTick) begin
            divCnt <= '0;
        end else if (!noClk) begin
            divCnt <= divCnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Successive approximation sequencer
    // ----------------------------------------
    logic [adcs_pkg::RES_W-1:0] trial;
    wire [3:0] bitIdx = 4'(adcs_pkg::RES_W) - bitCnt;
    wire [adcs_pkg::RES_W-1:0] clrMask = cmpSync ? '0 :
        adcs_pkg::RES_W'(1) << bitIdx;
    wire [adcs_pkg::RES_W-1:0] setMask = (bitIdx == 4'h0) ? '0 :
        adcs_pkg::RES_W'(1) << (bitIdx - 4'h1);
    wire [adcs_pkg::RES_W-1:0] next_trial = (bitCnt == 4'h0) ? trial :
        (trial & ~clrMask) | setMask;
    wire lastTad = bitCnt == 4'(adcs_pkg::CONV_TADS - 1);
    assign done = state == adcs_pkg::ST_CONV && tadTick && lastTad;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= adcs_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            trial <= '0;
            result <= '0;
            convDone <= 1'b0;
        end else begin
            convDone <= done; // R21
            case (state)
                adcs_pkg::ST_IDLE: begin
                    if (startReq) begin
                        state <= adcs_pkg::ST_CONV;
                        bitCnt <= 4'h0;
                        trial <= adcs_pkg::RES_W'(1) <<
                            (adcs_pkg::RES_W - 1); // R20
                    end
                end
                adcs_pkg::ST_CONV: begin
                    if (done) begin
                        result <= next_trial; // R21 R23
                        state <= adcs_pkg::ST_IDLE;
                    end else if (abort) begin
                        state <= adcs_pkg::ST_RECOV; // R22
                        bitCnt <= 4'h0;
                    end else if (tadTick) begin
                        trial <= next_trial;
                        bitCnt <= bitCnt + 4'h1; // R23
                    end
                end
                adcs_pkg::ST_RECOV: begin
                    if (noClk || asleepOrOff ||
                        (tadTick && bitCnt ==
                        4'(adcs_pkg::ABORT_TADS - 1))) begin
                        state <= adcs_pkg::ST_IDLE; // R22
                    end else if (tadTick) begin
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                default: state <= adcs_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Analog control outputs
    // ----------------------------------------
    wire srcInt = srcSel <= adcs_pkg::SRC_INT_LAST &&
        srcSel != adcs_pkg::SRC_RSV_A &&
        srcSel != adcs_pkg::SRC_RSV_B; // R2 R3
    wire srcPin = srcSel >= adcs_pkg::SRC_PIN_FIRST &&
        (srcSel < adcs_pkg::SRC_PIN_BIG || LARGE_PKG); // R4
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            anaCtl <= '0;
        end else begin
            anaCtl.power <= !asleepOrOff; // R1 R7
            anaCtl.refSel <= refSel; // R10
            anaCtl.src <= srcSel;
            anaCtl.srcValid <= srcInt || srcPin; // R3
            // Hold switch only opens; no discharge path exists
            anaCtl.sample <= !asleepOrOff &&
                state == adcs_pkg::ST_IDLE; // R19
            anaCtl.trial <= trial;
        end
    end

    // ----------------------------------------
    // Bus read path
    // ----------------------------------------
    logic [7:0] rdByte;
    logic rdHit;
    always_comb begin
        rdHit = 1'b1;
        case (s_axi_araddr)
            adcs_pkg::OFF_CTL0:
                rdByte = {1'b0, srcSel, goBit, convEn}; // R13 R5
            adcs_pkg::OFF_CTL1:
                rdByte = {1'b0, clkSel, 3'h0, refSel}; // R13
            adcs_pkg::OFF_RESH:
                rdByte = {6'h00, result[9:8]}; // R11
            adcs_pkg::OFF_RESL:
                rdByte = result[7:0]; // R12
            default: begin
                rdByte = 8'h00;
                rdHit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= adcs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rdByte};
            s_axi_rresp <= rdHit ? adcs_pkg::RESP_OKAY :
                adcs_pkg::RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [3:0] tickSeen;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tickSeen <= 4'h0;
        end else if (startReq) begin
            tickSeen <= 4'h0;
        end else if (state == adcs_pkg::ST_CONV && tadTick) begin
            tickSeen <= tickSeen + 4'h1;
        end
    end
    chk_go_clear: assert property (done |=> !goBit && convDone) // R6
        else $error("go bit not cleared at completion");
    chk_start_off: assert property (wrCtl0 && !convEn && !goBit
        |=> !goBit && state == adcs_pkg::ST_IDLE) // R24
        else $error("start accepted while disabled");
    chk_result_load: assert property (done
        |=> result == $past(next_trial)) // R21
        else $error("result not loaded at completion");
    chk_abort_keep: assert property (abort && !startReq
        |=> $stable(result) ##1 $stable(result)) // R22
        else $error("result changed on abort");
    chk_sleep_idle: assert property (sleepSync
        |=> !goBit && !anaCtl.power) // R1
        else $error("converter active in sleep");
    chk_conv_len: assert property (done
        |-> tickSeen == 4'(adcs_pkg::CONV_TADS - 1)) // R23
        else $error("conversion length wrong");
    chk_rsv_clock: assert property (noClk && state == adcs_pkg::ST_CONV
        |=> !done && $stable(trial)) // R9
        else $error("progress without conversion clock");
    chk_rsv_source: assert property (srcSel == adcs_pkg::SRC_RSV_A
        |=> !anaCtl.srcValid) // R3
        else $error("reserved source marked valid");
    chk_high_zero: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == adcs_pkg::OFF_RESH
        |=> s_axi_rdata[31:2] == '0) // R11
        else $error("upper result reserved bits set");
    chk_div8_tad: assert property (clkSel == adcs_pkg::CK_DIV8 &&
        tadTick && state != adcs_pkg::ST_IDLE && !abort
        |=> !tadTick [*7]) // R8
        else $error("divide by 8 period wrong");
    chk_ctl1_zero: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == adcs_pkg::OFF_CTL1
        |=> s_axi_rdata[3:1] == 3'h0 && !s_axi_rdata[7]) // R13
        else $error("unimplemented control bits set");
    chk_busy_go: assert property (goBit ==
        (state == adcs_pkg::ST_CONV)) // R5
        else $error("go bit disagrees with conversion state");
    cov_pin_src: cover property (anaCtl.srcValid &&
        anaCtl.src >= adcs_pkg::SRC_PIN_FIRST);
    cov_done: cover property (done);
    cov_abort: cover property (abortSw);
    cov_recov: cover property (state == adcs_pkg::ST_RECOV ##1
        state == adcs_pkg::ST_IDLE);
endmodule // adcs_top
